// ### rtl/pfis_pkg.sv
// Shared constants for the program-flow and interrupt-stack unit
package pfis_pkg;
  localparam int PC_W = 14;
  localparam logic [13:0] PC_RESET = 14'h0000;
  localparam logic [7:0] SP_RESET = 8'h00;
  localparam logic [13:0] PROG_START = 14'h0018;
  localparam logic [13:0] PROG_LAST = 14'h0BDF;
  localparam int PROG_RSVD_TOP = 32;
  // Vector table, one entry per interrupt source
  localparam logic [13:0] VEC_BUS_RESET = 14'h0002;
  localparam logic [13:0] VEC_TICK_128US = 14'h0004;
  localparam logic [13:0] VEC_TICK_1MS = 14'h0006;
  localparam logic [13:0] VEC_EP_CTRL = 14'h0008;
  localparam logic [13:0] VEC_EP_DATA = 14'h000A;
  localparam logic [13:0] VEC_GPIO = 14'h0014;
  localparam logic [13:0] VEC_WAKE = 14'h0016;
  localparam int IRQ_N = 7;
  // I/O register offsets
  localparam logic [7:0] IO_PORT0_PIN_DATA = 8'h00;
  localparam logic [7:0] IO_PORT1_PIN_DATA = 8'h01;
  localparam logic [7:0] IO_AUX_INPUT_PINS = 8'h02;
  localparam logic [7:0] IO_PORT0_PIN_IRQ_MASK = 8'h04;
  localparam logic [7:0] IO_PORT1_PIN_IRQ_MASK = 8'h05;
  localparam logic [7:0] IO_PORT0_IRQ_EDGE_SELECT = 8'h06;
  localparam logic [7:0] IO_PORT1_IRQ_EDGE_SELECT = 8'h07;
  localparam logic [7:0] IO_PORT0_DRIVE_CFG_LOW = 8'h0A;
  localparam logic [7:0] IO_PORT0_DRIVE_CFG_HIGH = 8'h0B;
  localparam logic [7:0] IO_PORT1_DRIVE_CFG_LOW = 8'h0C;
  localparam logic [7:0] IO_PORT1_DRIVE_CFG_HIGH = 8'h0D;
  localparam logic [7:0] IO_BUS_DEVICE_ADDRESS = 8'h10;
  localparam logic [7:0] IO_CONTROL_EP_COUNT = 8'h11;
  localparam logic [7:0] IO_CONTROL_EP_CONFIG = 8'h12;
  localparam logic [7:0] IO_DATA_EP_COUNT = 8'h13;
  localparam logic [7:0] IO_DATA_EP_CONFIG = 8'h14;
  localparam logic [7:0] IO_BUS_LINK_STATUS_CTRL = 8'h1F;
  localparam logic [7:0] IO_GLOBAL_IRQ_MASK = 8'h20;
  localparam logic [7:0] IO_ENDPOINT_IRQ_MASK = 8'h21;
  localparam logic [7:0] IO_FREE_TIMER_LOW = 8'h24;
  localparam logic [7:0] IO_FREE_TIMER_HIGH = 8'h25;
  localparam logic [7:0] IO_WATCHDOG_KICK = 8'h26;
  localparam logic [7:0] IO_CLOCK_SOURCE_CONFIG = 8'hF8;
  localparam logic [7:0] IO_CPU_STATUS_CONTROL = 8'hFF;
  // Reset value of the processor status register; arbitrary neutral value
  localparam logic [7:0] CPU_STATUS_RESET = 8'h01;
  // Free timer tick: 1 MHz from a 250 MHz core clock
  localparam int CLK_MHZ = 250;
  localparam int TIMER_MHZ = 1;
  localparam int TICK_DIV = CLK_MHZ / TIMER_MHZ;
  localparam int TIMER_W = 12;
  // Operation codes presented by the sequencer
  typedef enum logic [3:0] {
    OP_NONE, OP_NEXT, OP_PAGE_ADVANCE, OP_CALL, OP_SUB_EXIT, OP_IRQ_EXIT,
    OP_PORT_FETCH, OP_PORT_STORE, OP_INDEXED_PORT_STORE, OP_STACK_POINTER_LOAD
  } pfis_op_t;
endpackage : pfis_pkg

// ### rtl/pfis_io_regs.sv
// I/O register file: 256 byte-wide slots, registered read data
`timescale 1ns/1ps
module pfis_io_regs
  import pfis_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  input wire logic [TIMER_W-1:0] timer_val,
  input wire logic [7:0] aux_pins,
  output logic [7:0] rd_data
);
  typedef struct packed {
    logic [7:0] rd;
    logic [(1<<AW)*8-1:0] mem;
  } pfis_io_st_t;
  pfis_io_st_t s_q, s_d;
  logic [7:0] slot_rd;

  // Store each slot; watchdog clear is write-only and keeps nothing
  always_comb begin
    s_d = s_q;
    if (wr_en && wr_addr != IO_WATCHDOG_KICK) begin
      s_d.mem[wr_addr*8 +: 8] = wr_data;
    end
    slot_rd = s_q.mem[rd_addr*8 +: 8];
    case (rd_addr)
      IO_FREE_TIMER_LOW: s_d.rd = timer_val[7:0];
      IO_FREE_TIMER_HIGH: s_d.rd = {4'h0, timer_val[TIMER_W-1:8]};
      IO_AUX_INPUT_PINS: s_d.rd = aux_pins;
      IO_WATCHDOG_KICK: s_d.rd = 8'h00;
      default: s_d.rd = slot_rd;
    endcase
  end

  // Reset zeroes every slot except processor status
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.mem[IO_CPU_STATUS_CONTROL*8 +: 8] <= CPU_STATUS_RESET;
    end else begin
      s_q <= s_d;
    end
  end
  assign rd_data = s_q.rd;
endmodule : pfis_io_regs

// ### rtl/pfis_core.sv
// Program-flow, return stack and interrupt stacking unit
`timescale 1ns/1ps
module pfis_core
  import pfis_pkg::*;
#(
  parameter int SP_W = 8
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic OP_VALID,
  input wire logic [3:0] OP_CODE,
  input wire logic [7:0] OP_LEN,
  input wire logic [7:0] OP_ADDR,
  input wire logic [13:0] OP_TARGET,
  input wire logic [7:0] ACC_IN,
  input wire logic [7:0] INDEX_IN,
  input wire logic CARRY_IN,
  input wire logic ZERO_IN,
  input wire logic IRQ_GLOBAL_EN,
  input wire logic [IRQ_N-1:0] IRQ_REQ,
  input wire logic [7:0] RAM_RDATA,
  input wire logic [7:0] AUX_PINS,
  output logic OP_READY,
  output logic [13:0] FETCH_ADDR,
  output logic [7:0] STACK_PTR,
  output logic RAM_WE,
  output logic [7:0] RAM_ADDR,
  output logic [7:0] RAM_WDATA,
  output logic [7:0] ACC_OUT,
  output logic ACC_LOAD,
  output logic CARRY_OUT,
  output logic ZERO_OUT,
  output logic FLAGS_LOAD,
  output logic IRQ_ENABLED,
  output logic [IRQ_N-1:0] IRQ_ACK,
  output logic WATCHDOG_KICK,
  output logic [TIMER_W-1:0] FREE_TIMER
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_PUSH_HI, ST_PUSH_LO, ST_POP_LO, ST_POP_HI, ST_POP_DONE, ST_PORT_RD
  } pfis_state_t;

  typedef struct packed {
    pfis_state_t st;
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] sp;
    logic irq_en;
    logic [7:0] lo_byte;
    logic [13:0] push_val;
    logic push_c;
    logic push_z;
    logic [7:0] tick_cnt;
    logic [TIMER_W-1:0] timer;
    logic we;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic acc_ld;
    logic flags_ld;
    logic c;
    logic z;
    logic [IRQ_N-1:0] ack;
    logic wdk;
  } pfis_core_st_t;

  pfis_core_st_t s_q, s_d;
  logic [IRQ_N-1:0] pend;
  logic [2:0] pick;
  logic [13:0] vec;
  logic io_wr;
  logic [7:0] io_waddr;
  logic [7:0] io_rdata;
  logic idle;

  // Priority pick among the seven sources; lowest vector wins
  always_comb begin
    pend = IRQ_REQ & {IRQ_N{s_q.irq_en & IRQ_GLOBAL_EN}};
    pick = 3'h0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        pick = 3'(i);
      end
    end
    case (pick)
      3'h0: vec = VEC_BUS_RESET;
      3'h1: vec = VEC_TICK_128US;
      3'h2: vec = VEC_TICK_1MS;
      3'h3: vec = VEC_EP_CTRL;
      3'h4: vec = VEC_EP_DATA;
      3'h5: vec = VEC_GPIO;
      3'h6: vec = VEC_WAKE;
      default: vec = VEC_BUS_RESET;
    endcase
  end

  assign idle = (s_q.st == ST_IDLE);
  // Ops stall while the stacking sequence owns the RAM port
  assign OP_READY = idle && (pend == '0);

  // Port writes: indexed form adds the index to the address field
  always_comb begin
    io_wr = 1'b0;
    io_waddr = OP_ADDR;
    if (OP_VALID && OP_READY) begin
      if (pfis_op_t'(OP_CODE) == OP_PORT_STORE) begin
        io_wr = 1'b1;
      end else if (pfis_op_t'(OP_CODE) == OP_INDEXED_PORT_STORE) begin
        io_wr = 1'b1;
        io_waddr = 8'(OP_ADDR + INDEX_IN);
      end
    end
  end

  // Main sequencer
  always_comb begin
    s_d = s_q;
    s_d.we = 1'b0;
    s_d.acc_ld = 1'b0;
    s_d.flags_ld = 1'b0;
    s_d.ack = '0;
    s_d.wdk = io_wr && (io_waddr == IO_WATCHDOG_KICK);
    // Free timer prescaled to 1 MHz
    if (s_q.tick_cnt == 8'(TICK_DIV - 1)) begin
      s_d.tick_cnt = 8'h00;
      s_d.timer = s_q.timer + 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 1'b1;
    end
    case (s_q.st)
      ST_IDLE: begin
        if (pend != '0) begin
          // Acknowledge: mask further requests, stack the next address
          s_d.irq_en = 1'b0;
          s_d.ack = IRQ_N'(1) << pick;
          s_d.push_val = s_q.pc;
          s_d.push_c = CARRY_IN;
          s_d.push_z = ZERO_IN;
          s_d.pc = vec;
          s_d.st = ST_PUSH_HI;
        end else if (OP_VALID) begin
          case (pfis_op_t'(OP_CODE))
            OP_NEXT: s_d.pc = {s_q.pc[13:8], 8'(s_q.pc[7:0] + OP_LEN)};
            OP_PAGE_ADVANCE: s_d.pc = {6'(s_q.pc[13:8] + 1'b1), 8'h00};
            OP_CALL: begin
              s_d.push_val = {s_q.pc[13:8], 8'(s_q.pc[7:0] + OP_LEN)};
              s_d.push_c = CARRY_IN;
              s_d.push_z = ZERO_IN;
              s_d.pc = OP_TARGET;
              s_d.st = ST_PUSH_HI;
            end
            OP_SUB_EXIT, OP_IRQ_EXIT: begin
              s_d.sp = s_q.sp - 1'b1;
              s_d.st = ST_POP_LO;
            end
            OP_PORT_FETCH: s_d.st = ST_PORT_RD;
            OP_STACK_POINTER_LOAD: s_d.sp = ACC_IN;
            default: s_d.pc = s_q.pc;
          endcase
        end
      end
      ST_PUSH_HI: begin
        // First byte: flags and upper address bits at the current pointer
        s_d.we = 1'b1;
        s_d.waddr = s_q.sp;
        s_d.wdata = {s_q.push_c, s_q.push_z, s_q.push_val[13:8]};
        s_d.sp = s_q.sp + 1'b1;
        s_d.st = ST_PUSH_LO;
      end
      ST_PUSH_LO: begin
        s_d.we = 1'b1;
        s_d.waddr = s_q.sp;
        s_d.wdata = s_q.push_val[7:0];
        s_d.sp = s_q.sp + 1'b1;
        s_d.st = ST_IDLE;
      end
      ST_POP_LO: begin
        // Second byte is on the read port now; RAM reads combinationally
        s_d.lo_byte = RAM_RDATA;
        s_d.sp = s_q.sp - 1'b1;
        s_d.st = ST_POP_HI;
      end
      ST_POP_HI: begin
        // First byte: flags and upper address bits
        s_d.push_val = {RAM_RDATA[5:0], s_q.lo_byte};
        if (s_q.push_c) begin
          // Only the interrupt exit reloads flags and re-opens interrupts
          s_d.c = RAM_RDATA[7];
          s_d.z = RAM_RDATA[6];
          s_d.flags_ld = 1'b1;
          s_d.irq_en = 1'b1;
        end
        s_d.st = ST_POP_DONE;
      end
      ST_POP_DONE: begin
        // Still not idle here, so no new acknowledge before the pointer is back
        s_d.pc = s_q.push_val;
        s_d.st = ST_IDLE;
      end
      ST_PORT_RD: begin
        s_d.acc_ld = 1'b1;
        s_d.st = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
    // Remember which return flavour is being unstacked
    if (idle && pend == '0 && OP_VALID) begin
      if (pfis_op_t'(OP_CODE) == OP_IRQ_EXIT) begin
        s_d.push_c = 1'b1;
      end else if (pfis_op_t'(OP_CODE) == OP_SUB_EXIT) begin
        s_d.push_c = 1'b0;
      end
    end
  end

  // State register; reset clears pointer, stack and timer
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.pc <= PC_RESET;
      s_q.sp <= SP_RESET;
      s_q.irq_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  pfis_io_regs #(
    .AW(8)
  ) u_io (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .wr_en(io_wr),
    .wr_addr(io_waddr),
    .wr_data(ACC_IN),
    .rd_addr(OP_ADDR),
    .timer_val(s_q.timer),
    .aux_pins(AUX_PINS),
    .rd_data(io_rdata)
  );

  // RAM address: read side during unstack, write side otherwise
  assign RAM_ADDR = (s_q.st == ST_POP_LO || s_q.st == ST_POP_HI) ? s_q.sp : s_q.waddr;
  assign RAM_WE = s_q.we;
  assign RAM_WDATA = s_q.wdata;
  assign FETCH_ADDR = s_q.pc;
  assign STACK_PTR = s_q.sp;
  assign ACC_OUT = io_rdata;
  assign ACC_LOAD = s_q.acc_ld;
  assign CARRY_OUT = s_q.c;
  assign ZERO_OUT = s_q.z;
  assign FLAGS_LOAD = s_q.flags_ld;
  assign IRQ_ENABLED = s_q.irq_en;
  assign IRQ_ACK = s_q.ack;
  assign WATCHDOG_KICK = s_q.wdk;
  assign FREE_TIMER = s_q.timer;
endmodule : pfis_core

// ### dv/pfis_ram_model.sv
// Data RAM partner for the stack port
`timescale 1ns/1ps
module pfis_ram_model (
  input wire logic clk,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [256];
  // Pointer is the RAM address, so stacked bytes sit from 0x00 up
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end
  // Combinational read, as the unit expects
  assign rdata = mem[addr];
endmodule : pfis_ram_model

// ### dv/pfis_core_sva.sv
// Port checker for the program-flow unit
`timescale 1ns/1ps
module pfis_core_sva
  import pfis_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic OP_VALID,
  input wire logic OP_READY,
  input wire logic [3:0] OP_CODE,
  input wire logic [7:0] OP_LEN,
  input wire logic [7:0] OP_ADDR,
  input wire logic [7:0] ACC_IN,
  input wire logic [7:0] INDEX_IN,
  input wire logic [13:0] FETCH_ADDR,
  input wire logic [7:0] STACK_PTR,
  input wire logic RAM_WE,
  input wire logic [7:0] RAM_ADDR,
  input wire logic ACC_LOAD,
  input wire logic FLAGS_LOAD,
  input wire logic IRQ_ENABLED,
  input wire logic [IRQ_N-1:0] IRQ_ACK,
  input wire logic WATCHDOG_KICK
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // Op accepted at this edge
  wire take = OP_VALID && OP_READY;
  property p_rst; $rose(RESET_N) |-> FETCH_ADDR == 14'h0000 && STACK_PTR == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("pointers not cleared");
  property p_wrap; take && OP_CODE == OP_NEXT |=> FETCH_ADDR[13:8] == $past(FETCH_ADDR[13:8])
    && FETCH_ADDR[7:0] == $past(FETCH_ADDR[7:0] + OP_LEN); endproperty
  a_wrap: assert property (p_wrap) else $error("advance left page");
  property p_page; take && OP_CODE == OP_PAGE_ADVANCE |=>
    FETCH_ADDR == {$past(FETCH_ADDR[13:8]) + 6'h01, 8'h00}; endproperty
  a_page: assert property (p_page) else $error("page advance wrong");
  property p_push; (|IRQ_ACK) |-> !IRQ_ENABLED ##1 RAM_WE && RAM_ADDR == $past(STACK_PTR)
    ##1 RAM_WE && RAM_ADDR == $past(RAM_ADDR) + 8'h01 && STACK_PTR == $past(STACK_PTR, 2) + 8'h02; endproperty
  a_push: assert property (p_push) else $error("stacking wrong");
  property p_pop; take && OP_CODE == OP_IRQ_EXIT |-> ##1 RAM_ADDR == $past(STACK_PTR) - 8'h01
    ##1 RAM_ADDR == $past(STACK_PTR, 2) - 8'h02 ##1 FLAGS_LOAD && IRQ_ENABLED; endproperty
  a_pop: assert property (p_pop) else $error("unstacking wrong");
  property p_en; $rose(IRQ_ENABLED) |-> FLAGS_LOAD; endproperty
  a_en: assert property (p_en) else $error("enabled before restore");
  property p_sub; take && OP_CODE == OP_SUB_EXIT |=> !FLAGS_LOAD [*4]; endproperty
  a_sub: assert property (p_sub) else $error("flags restored by plain return");
  property p_spl; take && OP_CODE == OP_STACK_POINTER_LOAD |=> STACK_PTR == $past(ACC_IN); endproperty
  a_spl: assert property (p_spl) else $error("pointer load wrong");
  property p_rd; take && OP_CODE == OP_PORT_FETCH |-> ##2 ACC_LOAD; endproperty
  a_rd: assert property (p_rd) else $error("port fetch late");
  property p_kick; take && OP_CODE == OP_INDEXED_PORT_STORE
    && OP_ADDR + INDEX_IN == IO_WATCHDOG_KICK |=> WATCHDOG_KICK; endproperty
  a_kick: assert property (p_kick) else $error("indexed kick missed");
endmodule : pfis_core_sva
bind pfis_core pfis_core_sva u_sva (.*);

// ### dv/pfis_core_tb.sv
// Self-checking bench for the program-flow unit
`timescale 1ns/1ps
module pfis_core_tb
  import pfis_pkg::*;
();
  logic CORE_CLK, RESET_N = 1'b0, OP_VALID = 1'b0, CARRY_IN = 1'b0, ZERO_IN = 1'b0, IRQ_GLOBAL_EN = 1'b0;
  logic [3:0] OP_CODE = 4'h0;
  logic [7:0] OP_LEN = 8'h00, OP_ADDR = 8'h00, ACC_IN = 8'h00, INDEX_IN = 8'h00, AUX_PINS = 8'h5A;
  logic [13:0] OP_TARGET = 14'h0000;
  logic [IRQ_N-1:0] IRQ_REQ = '0;
  logic [7:0] RAM_RDATA, STACK_PTR, RAM_ADDR, RAM_WDATA, ACC_OUT;
  logic [13:0] FETCH_ADDR;
  logic [IRQ_N-1:0] IRQ_ACK;
  logic OP_READY, RAM_WE, ACC_LOAD, CARRY_OUT, ZERO_OUT, FLAGS_LOAD, IRQ_ENABLED, WATCHDOG_KICK;
  logic [TIMER_W-1:0] FREE_TIMER;
  int err_count = 0;
  int compares = 0;
  // Rows: address, value stored, value fetched back; only listed addresses
  logic [23:0] rows [5] = '{24'h10A5A5, 24'h203C3C, 24'h136B6B, 24'h267700, 24'h02FF5A};
  logic [13:0] vecs [7] = '{VEC_BUS_RESET, VEC_TICK_128US, VEC_TICK_1MS, VEC_EP_CTRL, VEC_EP_DATA, VEC_GPIO, VEC_WAKE};
  pfis_core uut (.*);
  pfis_ram_model ram (.clk(CORE_CLK), .we(RAM_WE), .addr(RAM_ADDR), .wdata(RAM_WDATA), .rdata(RAM_RDATA));
  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("err_count=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic tick(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask : tick
  // Waits for ready so the op is taken at the next edge; returns one cycle after
  task automatic op(input logic [3:0] c, input logic [7:0] a, input logic [7:0] acc);
    int n;
    // One edge between calls so the valid strobe is never re-raised in the same step
    tick(1);
    n = 0;
    while (OP_READY !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    OP_VALID = 1'b1;
    OP_CODE = c;
    OP_ADDR = a;
    ACC_IN = acc;
    tick(1);
    OP_VALID = 1'b0;
  endtask : op
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    op(OP_PORT_FETCH, a, 8'h00);
    n = 0;
    while (ACC_LOAD !== 1'b1 && n < 4) begin
      tick(1);
      n++;
    end
    d = ACC_OUT;
  endtask : rd
  // Main sequence
  initial begin
    logic [7:0] v;
    logic [11:0] t0;
    int n;
    tick(8);
    RESET_N = 1'b1;
    chk(FETCH_ADDR, PC_RESET);
    chk(STACK_PTR, SP_RESET);
    rd(IO_CPU_STATUS_CONTROL, v);
    chk(v, CPU_STATUS_RESET);
    rd(IO_GLOBAL_IRQ_MASK, v);
    chk(v, 8'h00);
    for (int i = 0; i < 5; i++) begin
      op(OP_PORT_STORE, rows[i][23:16], rows[i][15:8]);
      chk(WATCHDOG_KICK, rows[i][23:16] == IO_WATCHDOG_KICK);
      rd(rows[i][23:16], v);
      chk(v, rows[i][7:0]);
    end
    INDEX_IN = 8'h06;
    op(OP_INDEXED_PORT_STORE, 8'h20, 8'h11);
    chk(WATCHDOG_KICK, 1'b1);
    INDEX_IN = IO_BUS_DEVICE_ADDRESS;
    op(OP_INDEXED_PORT_STORE, 8'h00, 8'h5C);
    rd(IO_BUS_DEVICE_ADDRESS, v);
    chk(v, 8'h5C);
    t0 = FREE_TIMER;
    tick(TICK_DIV);
    chk(FREE_TIMER - t0, 16'h0001);
    // Second reset in mid-run, then page behaviour from a known pointer
    RESET_N = 1'b0;
    tick(2);
    RESET_N = 1'b1;
    chk(FETCH_ADDR, 14'h0000);
    OP_LEN = 8'hFF;
    op(OP_NEXT, 8'h00, 8'h00);
    chk(FETCH_ADDR, 14'h00FF);
    OP_LEN = 8'h02;
    op(OP_NEXT, 8'h00, 8'h00);
    chk(FETCH_ADDR, 14'h0001);
    op(OP_PAGE_ADVANCE, 8'h00, 8'h00);
    chk(FETCH_ADDR, 14'h0100);
    op(OP_STACK_POINTER_LOAD, 8'h00, 8'h40);
    chk(STACK_PTR, 8'h40);
    // Masked sources must not be taken
    IRQ_REQ = 7'h7F;
    tick(4);
    chk(IRQ_ACK, 7'h00);
    IRQ_REQ = '0;
    IRQ_GLOBAL_EN = 1'b1;
    for (int i = 0; i < IRQ_N; i++) begin
      CARRY_IN = i[0];
      ZERO_IN = i[1];
      IRQ_REQ = 7'h01 << i;
      n = 0;
      while (IRQ_ACK == 7'h00 && n < 10) begin
        tick(1);
        n++;
      end
      IRQ_REQ = '0;
      chk(FETCH_ADDR, vecs[i]);
      chk(IRQ_ENABLED, 1'b0);
      tick(3);
      chk(STACK_PTR, 8'h42);
      chk(ram.mem[8'h40], {i[0], i[1], 6'h01});
      chk(ram.mem[8'h41], 8'h00);
      op(OP_IRQ_EXIT, 8'h00, 8'h00);
      tick(2);
      chk({FLAGS_LOAD, CARRY_OUT, ZERO_OUT}, {1'b1, i[0], i[1]});
      chk(IRQ_ENABLED, 1'b1);
      tick(1);
      chk({FETCH_ADDR, STACK_PTR}, {14'h0100, 8'h40});
    end
    OP_TARGET = 14'h0200;
    op(OP_CALL, 8'h00, 8'h00);
    tick(2);
    chk({FETCH_ADDR, STACK_PTR}, {14'h0200, 8'h42});
    op(OP_SUB_EXIT, 8'h00, 8'h00);
    tick(3);
    chk(FETCH_ADDR, 14'h0102);
    end_of_test();
  end
  // Hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    err_count++;
    end_of_test();
  end
endmodule : pfis_core_tb
